/* logic/trc_pkg.sv */
package trc_pkg;
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;
   localparam logic [IDX_W-1:0] IDX_RATE_LO = 10'h10c;
   localparam logic [IDX_W-1:0] IDX_RATE_DEV = 10'h10d;
   localparam logic [IDX_W-1:0] IDX_DEV_HI = 10'h10e;
   localparam logic [IDX_W-1:0] IDX_AMP = 10'h114;
   localparam logic [IDX_W-1:0] IDX_MOD = 10'h115;
   localparam logic [IDX_W-1:0] IDX_FINE = 10'h307;
   localparam logic [IDX_W-1:0] IDX_CTRL = 10'h3f0;
   localparam logic [IDX_W-1:0] IDX_STAT = 10'h3f1;
   // field positions
   localparam int AMP_TOPO_BIT = 0;
   localparam int AMP_COARSE_LSB = 1;
   localparam int AMP_RAMP_LSB = 5;
   localparam int RATE_HI_LSB = 0;
   localparam int DEV_LO_LSB = 4;
   localparam int MOD_LSB = 0;
   localparam int CTRL_TX_BIT = 0;
   // reset values
   localparam logic [7:0] RST_RATE_LO = 8'h00;
   localparam logic [7:0] RST_RATE_DEV = 8'h00;
   localparam logic [7:0] RST_DEV_HI = 8'h00;
   localparam logic [7:0] RST_AMP = 8'h00;
   localparam logic [7:0] RST_MOD = 8'h00;
   localparam logic [5:0] RST_FINE = 6'h03;
   // coarse to fine mapping
   localparam logic [5:0] COARSE_MUL = 6'h04;
   localparam logic [5:0] COARSE_ADD = 6'h03;
   // gaussian bandwidth-time product times ten
   localparam logic [3:0] GAUSS_BT_X10 = 4'h5;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int ACC_W = 28;
   localparam logic [ACC_W-1:0] CLK_HZ = 28'(1000000000 / CLK_PERIOD_NS);
   localparam logic [ACC_W-1:0] RATE_UNIT_BPS = 28'h64;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      TRC_MOD_FSK = 2'b00,
      TRC_MOD_GFSK = 2'b01,
      TRC_MOD_MSK = 2'b10,
      TRC_MOD_GMSK = 2'b11
   } trc_mod_t;

   typedef enum logic [3:0] {
      TRC_IDLE = 4'b0001,
      TRC_UP = 4'b0010,
      TRC_HOLD = 4'b0100,
      TRC_DOWN = 4'b1000
   } trc_ramp_state_t;

   // power codes stepped per data bit for each ramp select
   function automatic logic [7:0] trc_codes_per_bit(input logic [2:0] sel);
      trc_codes_per_bit = 8'h01 << sel;
   endfunction

   function automatic logic [5:0] trc_coarse_to_fine(input logic [3:0] c);
      trc_coarse_to_fine = 6'(COARSE_MUL * {2'b00, c} + COARSE_ADD);
   endfunction
endpackage

/* logic/trc_step_gen.sv */
`timescale 1ns/100ps
module trc_step_gen
   import trc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // step rate in codes per second
   input wire logic [trc_pkg::ACC_W-1:0] inc_i,
   output logic step_o
);
   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] sum;
   logic wrap;
   // fractional accumulator, so any rate lands without a divider
   assign sum = acc + inc_i;
   assign wrap = sum >= CLK_HZ;

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         acc <= '0;
         step_o <= 1'b0;
      end
      else
      begin
         acc <= wrap ? sum - CLK_HZ : sum;
         step_o <= wrap;
      end
   end
endmodule

/* logic/trc_ramp_engine.sv */
`timescale 1ns/100ps
module trc_ramp_engine
   import trc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // control
   input wire logic tx_request_i,
   input wire logic output_topology_select_i,
   input wire logic [5:0] target_i,
   input wire logic step_i,
   // amplifier drive
   output logic [5:0] power_code_o,
   output logic se_en_o,
   output logic diff_en_o,
   output logic [3:0] state_o
);
   trc_ramp_state_t state;
   trc_ramp_state_t next_state;
   logic topo;

   always_comb
   begin
      next_state = state;
      unique case (state)
         TRC_IDLE: if (tx_request_i) next_state = TRC_UP;
         TRC_UP:
            if (!tx_request_i) next_state = TRC_DOWN;
            else if (step_i && power_code_o + 6'h01 >= target_i)
               next_state = TRC_HOLD;
         TRC_HOLD: if (!tx_request_i) next_state = TRC_DOWN;
         TRC_DOWN:
            if (step_i && power_code_o <= 6'h01)
               next_state = TRC_IDLE;
         default: next_state = TRC_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         state <= TRC_IDLE;
         power_code_o <= '0;
         topo <= 1'b0;
      end
      else
      begin
         state <= next_state;
         // topology frozen per burst so a mid-burst write cannot swap outputs
         if (state == TRC_IDLE)
            topo <= output_topology_select_i;
         if (state == TRC_IDLE)
            power_code_o <= '0;
         else if (state == TRC_UP && step_i && power_code_o < target_i)
            power_code_o <= power_code_o + 6'h01;
         else if (state == TRC_HOLD)
            power_code_o <= target_i;
         else if (state == TRC_DOWN && step_i && power_code_o != 6'h00)
            power_code_o <= power_code_o - 6'h01;
      end
   end

   // enables registered from the combinational next state and one topology bit
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         se_en_o <= 1'b0;
         diff_en_o <= 1'b0;
      end
      else
      begin
         se_en_o <= next_state != TRC_IDLE && !topo;
         diff_en_o <= next_state != TRC_IDLE && topo;
      end
   end

   assign state_o = state;
endmodule

/* logic/trc_tx_config.sv */
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module trc_tx_config
   import trc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // axi4-lite write address
   input wire logic [trc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [trc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // modulator settings
   output logic [1:0] modulation_o,
   output logic gaussian_en_o,
   output logic [3:0] gauss_bt_x10_o,
   output logic [11:0] tone_deviation_o,
   output logic [11:0] symbol_rate_o,
   // amplifier drive
   output logic [5:0] power_code_o,
   output logic single_ended_en_o,
   output logic differential_en_o
);
   // register storage
   logic [7:0] radio_config_rate_low;
   logic [7:0] radio_config_rate_deviation_shared;
   logic [7:0] radio_config_deviation_high;
   logic [7:0] radio_config_amplifier;
   logic [7:0] radio_config_modulation;
   logic [5:0] fine_power_level;
   logic tx_request;

   // write channel state
   logic aw_held;
   logic w_held;
   logic [IDX_W-1:0] wr_idx;
   logic [7:0] wr_byte;
   logic wr_lane0;

   // handshakes
   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic b_fire;
   logic r_fire;
   logic commit;
   logic wr_en;

   // decoded fields
   logic [11:0] symbol_rate;
   logic [11:0] tone_deviation;
   logic output_topology_select;
   logic [3:0] coarse_power_code;
   logic [2:0] ramp_rate_select;
   logic [1:0] modulation;
   logic [5:0] fine_power_code;

   // read path
   logic [IDX_W-1:0] rd_idx;
   logic [31:0] rd_word;
   logic rd_mapped;
   logic wr_mapped;

   // ramp timing
   logic [ACC_W-1:0] step_inc;
   logic step;
   logic [3:0] ramp_state;
   logic [5:0] ramp_code;
   logic se_en;
   logic diff_en;

   function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
      idx_mapped = idx == IDX_RATE_LO || idx == IDX_RATE_DEV
         || idx == IDX_DEV_HI || idx == IDX_AMP || idx == IDX_MOD
         || idx == IDX_FINE || idx == IDX_CTRL || idx == IDX_STAT;
   endfunction

   assign aw_fire = s_axi_awvalid && s_axi_awready;
   assign w_fire = s_axi_wvalid && s_axi_wready;
   assign ar_fire = s_axi_arvalid && s_axi_arready;
   assign b_fire = s_axi_bvalid && s_axi_bready;
   assign r_fire = s_axi_rvalid && s_axi_rready;
   // both halves held, response slot free
   assign commit = aw_held && w_held && !s_axi_bvalid;
   assign wr_mapped = idx_mapped(wr_idx);
   // registers are one byte wide, only lane 0 carries them
   assign wr_en = commit && wr_lane0 && wr_mapped;

   // field decode
   assign symbol_rate = {
      radio_config_rate_deviation_shared[RATE_HI_LSB +: 4],
      radio_config_rate_low
   };
   assign tone_deviation = {
      radio_config_deviation_high,
      radio_config_rate_deviation_shared[DEV_LO_LSB +: 4]
   };
   assign output_topology_select =
      radio_config_amplifier[AMP_TOPO_BIT];
   assign coarse_power_code =
      radio_config_amplifier[AMP_COARSE_LSB +: 4];
   assign ramp_rate_select =
      radio_config_amplifier[AMP_RAMP_LSB +: 3];
   assign modulation = radio_config_modulation[MOD_LSB +: 2];
   assign fine_power_code = fine_power_level;

   // steps per second = bits per second times codes per bit
   assign step_inc = ACC_W'(
      {16'h0000, symbol_rate} * RATE_UNIT_BPS
      * {20'h00000, trc_codes_per_bit(ramp_rate_select)});

   // write address and data capture
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_idx <= '0;
         wr_byte <= '0;
         wr_lane0 <= 1'b0;
      end
      else
      begin
         if (aw_fire)
         begin
            aw_held <= 1'b1;
            wr_idx <= s_axi_awaddr[ADDR_W-1:2];
         end
         else if (commit)
            aw_held <= 1'b0;
         if (w_fire)
         begin
            w_held <= 1'b1;
            wr_byte <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
         end
         else if (commit)
            w_held <= 1'b0;
      end
   end

   // ready flags drop once a half is taken and return after the response
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held && !aw_fire && !commit
            && !s_axi_bvalid;
         s_axi_wready <= !w_held && !w_fire && !commit
            && !s_axi_bvalid;
         if (commit)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         else if (b_fire)
            s_axi_bvalid <= 1'b0;
      end
   end

   // register writes
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         radio_config_rate_low <= RST_RATE_LO;
         radio_config_rate_deviation_shared <= RST_RATE_DEV;
         radio_config_deviation_high <= RST_DEV_HI;
         radio_config_amplifier <= RST_AMP;
         radio_config_modulation <= RST_MOD;
         fine_power_level <= RST_FINE;
         tx_request <= 1'b0;
      end
      else if (wr_en)
      begin
         unique case (wr_idx)
            IDX_RATE_LO: radio_config_rate_low <= wr_byte;
            IDX_RATE_DEV: radio_config_rate_deviation_shared <= wr_byte;
            IDX_DEV_HI: radio_config_deviation_high <= wr_byte;
            IDX_AMP:
            begin
               radio_config_amplifier <= wr_byte;
               // a coarse write sets the fine code it stands for
               fine_power_level <= trc_coarse_to_fine(
                  wr_byte[AMP_COARSE_LSB +: 4]);
            end
            IDX_MOD: radio_config_modulation <= wr_byte;
            IDX_FINE: fine_power_level <= wr_byte[5:0];
            IDX_CTRL: tx_request <= wr_byte[CTRL_TX_BIT];
            default: tx_request <= tx_request;
         endcase
      end
   end

   // read mux
   assign rd_idx = s_axi_araddr[ADDR_W-1:2];
   assign rd_mapped = idx_mapped(rd_idx);
   always_comb
   begin
      rd_word = '0;
      unique case (rd_idx)
         IDX_RATE_LO: rd_word[7:0] = radio_config_rate_low;
         IDX_RATE_DEV: rd_word[7:0] = radio_config_rate_deviation_shared;
         IDX_DEV_HI: rd_word[7:0] = radio_config_deviation_high;
         IDX_AMP: rd_word[7:0] = radio_config_amplifier;
         IDX_MOD: rd_word[7:0] = radio_config_modulation;
         IDX_FINE: rd_word[5:0] = fine_power_level;
         IDX_CTRL: rd_word[CTRL_TX_BIT] = tx_request;
         IDX_STAT:
            rd_word[13:0] = {diff_en, se_en, ramp_state, 2'b00, ramp_code};
         default: rd_word = '0;
      endcase
   end

   // read channel, one read in flight
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !ar_fire;
         if (ar_fire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         else if (r_fire)
            s_axi_rvalid <= 1'b0;
      end
   end

   // modulator outputs registered for clean pins
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         modulation_o <= TRC_MOD_FSK;
         gaussian_en_o <= 1'b0;
         gauss_bt_x10_o <= GAUSS_BT_X10;
         tone_deviation_o <= '0;
         symbol_rate_o <= '0;
      end
      else
      begin
         modulation_o <= modulation;
         gaussian_en_o <= modulation == TRC_MOD_GFSK
            || modulation == TRC_MOD_GMSK;
         gauss_bt_x10_o <= GAUSS_BT_X10;
         tone_deviation_o <= tone_deviation;
         symbol_rate_o <= symbol_rate;
      end
   end

   // a zero symbol rate gives no steps, so a ramp then stalls by design;
   // software keeps the rate within the spectral limit on its own
   trc_step_gen i_trc_step_gen (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .inc_i(step_inc),
      .step_o(step)
   );

   trc_ramp_engine i_trc_ramp_engine (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .tx_request_i(tx_request),
      .output_topology_select_i(output_topology_select),
      .target_i(fine_power_code),
      .step_i(step),
      .power_code_o(ramp_code),
      .se_en_o(se_en),
      .diff_en_o(diff_en),
      .state_o(ramp_state)
   );

   assign power_code_o = ramp_code;
   assign single_ended_en_o = se_en;
   assign differential_en_o = diff_en;
endmodule

/* testbench/trc_tx_properties.sv */
`timescale 1ns/100ps
module trc_tx_properties (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // watched outputs
   input wire logic [1:0] modulation_o,
   input wire logic gaussian_en_o,
   input wire logic [3:0] gauss_bt_x10_o,
   input wire logic [5:0] power_code_o,
   input wire logic single_ended_en_o,
   input wire logic differential_en_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   wire amp_en = single_ended_en_o || differential_en_o;
   sequence amp_on_s;
      $rose(amp_en);
   endsequence
   sequence amp_off_s;
      $fell(amp_en);
   endsequence
   excl_en_a: assert property (
      !(single_ended_en_o && differential_en_o))
      else $error("both enables high");
   bt_fixed_a: assert property (gauss_bt_x10_o == 4'h5)
      else $error("bt product changed");
   gauss_flag_a: assert property (
      gaussian_en_o == modulation_o[0]) else $error("gaussian flag wrong");
   off_zero_a: assert property (!amp_en |-> power_code_o == 6'h00)
      else $error("code not zero while off");
   // a jump of more than one code would splatter, so steps are single
   step_one_a: assert property (
      power_code_o - $past(power_code_o) inside {6'h00, 6'h01, 6'h3f})
      else $error("code jumped");
   rise_zero_a: assert property (amp_on_s |-> power_code_o <= 6'h01)
      else $error("ramp not from zero");
   fall_zero_a: assert property (
      amp_off_s |-> $past(power_code_o) <= 6'h01) else $error("off early");
   topo_hold_a: assert property (
      amp_en && $past(amp_en) |-> $stable(single_ended_en_o))
      else $error("topology changed in burst");
endmodule
bind trc_tx_config trc_tx_properties i_trc_tx_properties (.clk_sys_i,
   .rst_n_i, .modulation_o, .gaussian_en_o, .gauss_bt_x10_o,
   .power_code_o, .single_ended_en_o, .differential_en_o);

/* testbench/trc_pa_model.sv */
`timescale 1ns/100ps
module trc_pa_model (
   // clock
   input wire logic clk_sys_i,
   // amplifier drive
   input wire logic [5:0] power_code_i,
   input wire logic se_en_i,
   input wire logic diff_en_i,
   // observations
   output logic [5:0] peak_o = 6'h00,
   output logic clash_o = 1'b0
);
   // both stages share the antenna pins, a clash is sticky
   always @(posedge clk_sys_i)
   begin
      if (se_en_i && diff_en_i)
         clash_o <= 1'b1;
      if (!se_en_i && !diff_en_i)
         peak_o <= 6'h00;
      else if (power_code_i > peak_o)
         peak_o <= power_code_i;
   end
endmodule

/* testbench/test_trc_tx_config.sv */
`timescale 1ns/100ps
module test_trc_tx_config;
   import trc_pkg::*;
   typedef struct {
      logic [11:0] a;
      logic [7:0] d;
      logic [3:0] s;
      logic [7:0] rd;
      logic [1:0] rsp;
   } trc_row_t;
   typedef struct {
      logic t;
      logic [2:0] sel;
      logic [3:0] c;
      logic [5:0] f;
   } trc_ramp_t;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [11:0] s_axi_awaddr = '0;
   logic [11:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, gaussian_en_o, single_ended_en_o, differential_en_o;
   logic [1:0] s_axi_bresp, s_axi_rresp, modulation_o;
   logic [31:0] s_axi_rdata, d;
   logic [3:0] gauss_bt_x10_o;
   logic [11:0] tone_deviation_o, symbol_rate_o;
   logic [5:0] power_code_o, peak;
   logic clash;
   logic [1:0] r;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   // unmapped index and two strobe-off writes sit among ordinary rows
   trc_row_t rows[9] = '{
      '{12'h430, 8'hff, 4'h1, 8'hff, RESP_OKAY},
      '{12'h434, 8'h3f, 4'h1, 8'h3f, RESP_OKAY},
      '{12'h438, 8'h7e, 4'h1, 8'h7e, RESP_OKAY},
      '{12'h454, 8'h02, 4'h1, 8'h02, RESP_OKAY},
      '{12'hc1c, 8'hff, 4'h1, 8'h3f, RESP_OKAY},
      '{12'hc1c, 8'h01, 4'h0, 8'h3f, RESP_OKAY},
      '{12'h450, 8'h0a, 4'h1, 8'h0a, RESP_OKAY},
      '{12'hc1c, 8'h00, 4'h0, 8'h17, RESP_OKAY},
      '{12'h440, 8'h55, 4'h1, 8'h00, RESP_SLVERR}};
   // each rate kept within the spectral limit for a 4095 symbol rate
   trc_ramp_t ramps[4] = '{'{1'b0, 3'h4, 4'h2, 6'h00},
      '{1'b1, 3'h3, 4'h1, 6'h00}, '{1'b1, 3'h7, 4'h3, 6'h3c},
      '{1'b0, 3'h0, 4'h0, 6'h00}};

   always #4 clk_sys_i = ~clk_sys_i;

   trc_tx_config i_trc_tx_config (.clk_sys_i, .rst_n_i, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .modulation_o, .gaussian_en_o,
      .gauss_bt_x10_o, .tone_deviation_o, .symbol_rate_o, .power_code_o,
      .single_ended_en_o, .differential_en_o);
   trc_pa_model i_trc_pa_model (.clk_sys_i, .power_code_i(power_code_o),
      .se_en_i(single_ended_en_o), .diff_en_i(differential_en_o),
      .peak_o(peak), .clash_o(clash));

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         close_out();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v,
         input logic [3:0] s, output logic [1:0] rs);
      logic aw;
      logic w;
      @(posedge clk_sys_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, v};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b0;
      w = 1'b0;
      while (!(aw && w))
      begin
         @(posedge clk_sys_i);
         aw = aw | s_axi_awready;
         w = w | s_axi_wready;
         s_axi_awvalid <= ~aw;
         s_axi_wvalid <= ~w;
      end
      do
         @(posedge clk_sys_i);
      while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] v,
         output logic [1:0] rs);
      @(posedge clk_sys_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
         @(posedge clk_sys_i);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do
         @(posedge clk_sys_i);
      while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // rate is 4095 units, so a step comes every 1250000/(4095<<sel) cycles
   task automatic ramp(input trc_ramp_t c);
      int n;
      int p;
      logic [5:0] t;
      p = 1250000 / (4095 << c.sel);
      t = (c.f != 6'h00) ? c.f : 6'(4 * c.c + 3);
      wr(12'h450, {c.sel, c.c, c.t}, 4'h1, r);
      if (c.f != 6'h00)
         wr(12'hc1c, {2'b00, c.f}, 4'h1, r);
      wr(12'hfc0, 8'h01, 4'h1, r);
      for (n = 0; power_code_o !== t; n++)
         @(negedge clk_sys_i);
      check("up time", 32'(n >= (t - 1) * p && n <= (t + 1) * (p + 1) + 12),
         32'h1);
      check("se en", 32'(single_ended_en_o), 32'(!c.t));
      check("diff en", 32'(differential_en_o), 32'(c.t));
      // the model samples the code one edge after it lands
      @(negedge clk_sys_i);
      check("peak", 32'(peak), 32'(t));
      rd(12'hfc4, d, r);
      check("stat", d, 32'({c.t, !c.t, 4'b0100, 2'b00, t}));
      wr(12'hfc0, 8'h00, 4'h1, r);
      for (n = 0; single_ended_en_o | differential_en_o; n++)
         @(negedge clk_sys_i);
      check("down time", 32'(n <= (t + 1) * (p + 1) + 12), 32'h1);
      check("off code", 32'(power_code_o), 32'h0);
   endtask

   initial
   begin
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d, rows[i].s, r);
         check("wr resp", 32'(r), 32'(rows[i].rsp));
         rd(rows[i].a, d, r);
         check("rd data", d, 32'(rows[i].rd));
         check("rd resp", 32'(r), 32'(rows[i].rsp));
      end
      @(negedge clk_sys_i);
      check("rate", 32'(symbol_rate_o), 32'hfff);
      check("dev", 32'(tone_deviation_o), 32'h7e3);
      $display("test registers done");
      for (int m = 0; m < 4; m++)
      begin
         wr(12'h454, 8'(m), 4'h1, r);
         @(negedge clk_sys_i);
         check("mod", 32'(modulation_o), 32'(m));
         check("gauss", 32'(gaussian_en_o), 32'(m % 2));
         check("bt", 32'(gauss_bt_x10_o), 32'h5);
      end
      $display("test modulation done");
      foreach (ramps[i])
         ramp(ramps[i]);
      $display("test ramp done");
      // abort a slow climb to 63 just after it starts
      wr(12'h450, 8'h1e, 4'h1, r);
      wr(12'hfc0, 8'h01, 4'h1, r);
      repeat (400) @(negedge clk_sys_i);
      check("abort peak", 32'(peak < 6'h3f && peak > 6'h00), 32'h1);
      wr(12'hfc0, 8'h00, 4'h1, r);
      while (single_ended_en_o | differential_en_o)
         @(negedge clk_sys_i);
      check("abort code", 32'(power_code_o), 32'h0);
      $display("test abort done");
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(12'hc1c, d, r);
      check("fine rst", d, 32'h3);
      rd(12'h450, d, r);
      check("amp rst", d, 32'h0);
      check("mod rst", 32'(modulation_o), 32'h0);
      check("clash", 32'(clash), 32'h0);
      $display("test reset done");
      close_out();
   end
endmodule
